// ==== gmfm_pkg.sv ====
// shared constants for the governor mode and fault monitor
package gmfm_pkg;
    // ============================================================
    // clock and timing
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int PERSIST_TIME_MS = 650;
    localparam int ZERO_SPEED_TIME_US = 13000;
    localparam int PERSIST_CYC = PERSIST_TIME_MS * CLK_FREQ_KHZ;
    localparam int ZERO_SPEED_CYC = (ZERO_SPEED_TIME_US * CLK_FREQ_KHZ) / 1000;
    localparam int MS_TICK_CYC = CLK_FREQ_KHZ;
    localparam int CNT_W = 23;
    // ============================================================
    // thresholds: millivolts, degrees C (signed 12 bit)
    localparam logic [15:0] SUPPLY_HIGH_MV = 16'h80E8;
    localparam logic [15:0] SUPPLY_LOW_MV = 16'h186A;
    localparam logic [15:0] POS_HIGH_MV = 16'h128E;
    localparam logic [15:0] POS_LOW_MV = 16'h00FA;
    localparam logic signed [11:0] DERATE_START_C = 12'sh075;
    localparam logic signed [11:0] DERATE_ZERO_C = 12'sh07D;
    localparam logic signed [11:0] OTEMP_SET_C = 12'sh07D;
    localparam logic signed [11:0] OTEMP_CLR_C = 12'sh078;
    localparam logic signed [11:0] TSENS_HIGH_C = 12'sh096;
    localparam logic signed [11:0] TSENS_LOW_C = -12'sh02D;
    localparam logic signed [11:0] TSENS_HIGH_CLR_C = 12'sh091;
    localparam logic signed [11:0] TSENS_LOW_CLR_C = -12'sh028;
    localparam logic [7:0] CURRENT_FULL = 8'hFF;
    localparam int DERATE_SHIFT = 5;
    // ============================================================
    // fault indices
    localparam int NFLT = 7;
    localparam int F_SUPPLY = 0;
    localparam int F_TSENS = 1;
    localparam int F_OTEMP = 2;
    localparam int F_ZSPEED = 3;
    localparam int F_STOP = 4;
    localparam int F_NVM = 5;
    localparam int F_POS = 6;
    // faults that open the external status output
    localparam logic [6:0] EXT_STATUS_MASK = 7'h67;
    // ============================================================
    // register map (byte addresses) and reset values
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_START_SPD = 8'h04;
    localparam logic [7:0] REG_RUN_SPD = 8'h08;
    localparam logic [7:0] REG_SFL = 8'h0C;
    localparam logic [7:0] REG_STOP_DLY = 8'h10;
    localparam logic [7:0] REG_CMD = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_LOG = 8'h1C;
    localparam int CTRL_DUAL_BIT = 0;
    localparam int CTRL_PSTOP_BIT = 1;
    localparam int CTRL_HOLD_LSB = 8;
    localparam int CMD_RESET_BIT = 0;
    localparam int CMD_CLRLOG_BIT = 1;
    localparam int STAT_MODE_LSB = 8;
    localparam int STAT_HEALTHY_BIT = 16;
    localparam logic [15:0] RST_CTRL = 16'h4000;
    localparam logic [15:0] RST_START1 = 16'h0064;
    localparam logic [15:0] RST_START2 = 16'h00C8;
    localparam logic [15:0] RST_RUN_SPD = 16'h012C;
    localparam logic [15:0] RST_SFL1 = 16'h8000;
    localparam logic [15:0] RST_SFL2 = 16'h6000;
    localparam logic [15:0] RST_STOP_DLY = 16'h03E8;
    localparam logic [15:0] RAMP_STEP = 16'h0010;
    // ============================================================
    // control modes, one-hot
    typedef enum logic [6:0] {
        M_STOPPING = 7'h01,
        M_STOPPED = 7'h02,
        M_POWERDOWN = 7'h04,
        M_START1 = 7'h08,
        M_START2 = 7'h10,
        M_RAMPING = 7'h20,
        M_RATED = 7'h40
    } gmfm_mode_t;
endpackage : gmfm_pkg

// ==== gmfm_top.sv ====
// governor mode sequencer, fault monitor, current derate and AHB-Lite register file
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
// Function
// [R1] full current to 117C, linear to zero at 125C
// [R2] stopping drives closed, zero speed enters stopped
// [R3] stopped: hold current after delay, start if clear
// [R4] power-down only when stopped and run disabled
// [R5] speed over start1 selects start fuel one
// [R6] dual start: over start2 selects start fuel two
// [R7] any shutdown forces minimum fuel demand
// [R8] supply, sensor and over-temp faults clear themselves when condition goes
// [R9] any active fault drops healthy output
// [R10] every fault sets sticky log until cleared
// [R11] supply out of 6.25..33 V 650 ms
// [R12] temp sensor fault with five degree hysteresis
// [R13] over-temperature above 125, clear below 120
// [R14] hardware shutdowns open external status output
// [R15] zero speed stop until stopped or power-down
// [R16] stop input 650 ms, held until speed zero
// [R17] memory failure goes limp until reset
// [R18] position sensor fault drives failsafe, latches
// [R19] persistence timers restart when condition absent
// [R20] commanded stop gives minimum position demand
module gmfm_top
    import gmfm_pkg::*;
#(
    parameter int P_PERSIST_CYC = PERSIST_CYC,
    parameter int P_ZERO_SPEED_CYC = ZERO_SPEED_CYC,
    parameter int P_MS_TICK_CYC = MS_TICK_CYC
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // measurements and discrete inputs
    input wire logic [15:0] i_speed_rpm,
    input wire logic [15:0] i_supply_mv,
    input wire logic signed [11:0] i_board_temp_c,
    input wire logic [15:0] i_pos_sense_mv,
    input wire logic i_run_enable,
    input wire logic i_stop_open,
    input wire logic [15:0] i_rated_demand,
    // nonvolatile log memory
    input wire logic i_nvm_fail,
    input wire logic [6:0] i_nvm_log,
    output logic [6:0] o_nvm_log,
    output logic o_nvm_log_wr,
    // actuator and indications
    output logic [15:0] o_pos_demand,
    output logic [7:0] o_current_limit,
    output logic o_pos_ctrl_en,
    output logic o_hold_current,
    output logic o_failsafe_drive,
    output logic o_healthy,
    output logic o_ext_status_on,
    output logic [6:0] o_mode
);

    // ============================================================
    // elaboration checks
    if (P_PERSIST_CYC < 1 || P_PERSIST_CYC >= (1 << CNT_W)) begin : g_chk_persist
        $error("bad persistence count");
    end
    if (P_ZERO_SPEED_CYC < 1 || P_ZERO_SPEED_CYC >= (1 << CNT_W)) begin : g_chk_zspd
        $error("bad zero speed count");
    end
    if (P_MS_TICK_CYC < 1 || P_MS_TICK_CYC >= 65536) begin : g_chk_tick
        $error("bad tick count");
    end

    // ============================================================
    // state
    typedef struct packed {
        gmfm_mode_t mode;
        logic [NFLT-1:0] fault;
        logic [NFLT-1:0][CNT_W-1:0] pcnt;
        logic [NFLT-1:0] log;
        logic log_loaded;
        logic [15:0] ctrl, start1, start2, run_spd, sfl1, sfl2, stop_dly, ms_cnt, hold_cnt;
        logic ap_valid, ap_write;
        logic [7:0] ap_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic [15:0] demand;
        logic [7:0] climit;
        logic pos_en, hold, failsafe, healthy, ext_on, nvm_wr;
    } gmfm_state_t;

    gmfm_state_t s_q;
    gmfm_state_t s_d;

    // ============================================================
    // combinational helpers
    logic [NFLT-1:0] cond, clr_ok;
    logic [NFLT-1:0][CNT_W-1:0] plimit;
    logic shutdown, running, speed_zero, ms_tick, cmd_reset, cmd_clrlog, wr_en, ap_take;
    logic [7:0] derate;
    logic signed [11:0] derate_diff;

    // register read mux
    function automatic logic [31:0] gmfm_read(input gmfm_state_t s, input logic [7:0] addr);
        unique case (addr)
            REG_CTRL: return {16'h0000, s.ctrl};
            REG_START_SPD: return {s.start2, s.start1};
            REG_RUN_SPD: return {16'h0000, s.run_spd};
            REG_SFL: return {s.sfl2, s.sfl1};
            REG_STOP_DLY: return {16'h0000, s.stop_dly};
            REG_STATUS: return {15'h0000, s.healthy, 1'b0, s.mode, 1'b0, s.fault};
            REG_LOG: return {25'h0000000, s.log};
            default: return 32'h0000_0000;
        endcase
    endfunction : gmfm_read

    always_comb begin
        derate_diff = DERATE_ZERO_C - i_board_temp_c;
        speed_zero = (i_speed_rpm == 16'h0000);
        running = s_q.mode inside {M_START1, M_START2, M_RAMPING, M_RATED};
        ms_tick = (s_q.ms_cnt == 16'(P_MS_TICK_CYC - 1));
        // data phase of a write lands in the cycle after the address phase
        wr_en = s_q.ap_valid && s_q.ap_write;
        ap_take = i_hsel && i_htrans[1] && i_hready;
        cmd_reset = wr_en && (s_q.ap_addr == REG_CMD) && i_hwdata[CMD_RESET_BIT];
        cmd_clrlog = wr_en && (s_q.ap_addr == REG_CMD) && i_hwdata[CMD_CLRLOG_BIT];
    end

    // fault conditions and the conditions that let each fault drop
    always_comb begin
        // [R11] supply window
        cond[F_SUPPLY] = (i_supply_mv > SUPPLY_HIGH_MV) || (i_supply_mv < SUPPLY_LOW_MV);
        // [R12] sensor range
        cond[F_TSENS] = (i_board_temp_c > TSENS_HIGH_C) || (i_board_temp_c < TSENS_LOW_C);
        // [R13] over-temperature level
        cond[F_OTEMP] = (i_board_temp_c > OTEMP_SET_C);
        // [R15] below half start speed while running
        cond[F_ZSPEED] = running && (i_speed_rpm < {1'b0, s_q.start1[15:1]});
        // [R16] stop input or panel stop
        cond[F_STOP] = i_stop_open || s_q.ctrl[CTRL_PSTOP_BIT];
        cond[F_NVM] = i_nvm_fail;
        // [R18] position sensor window
        cond[F_POS] = (i_pos_sense_mv > POS_HIGH_MV) || (i_pos_sense_mv < POS_LOW_MV);
        // [R8] non-latching drops
        clr_ok[F_SUPPLY] = !cond[F_SUPPLY];
        // [R12] hysteresis clear
        clr_ok[F_TSENS] = (i_board_temp_c < TSENS_HIGH_CLR_C) && (i_board_temp_c > TSENS_LOW_CLR_C);
        // [R13] clear below 120
        clr_ok[F_OTEMP] = (i_board_temp_c < OTEMP_CLR_C);
        // [R15] safe state reached
        clr_ok[F_ZSPEED] = (s_q.mode == M_STOPPED) || (s_q.mode == M_POWERDOWN);
        // [R16] held until speed zero
        clr_ok[F_STOP] = speed_zero && !cond[F_STOP];
        // [R17] only system reset clears it
        clr_ok[F_NVM] = 1'b0;
        // [R18] latched until reset command
        clr_ok[F_POS] = cmd_reset && !cond[F_POS];
        plimit = {NFLT{CNT_W'(P_PERSIST_CYC)}};
        plimit[F_ZSPEED] = CNT_W'(P_ZERO_SPEED_CYC);
        plimit[F_NVM] = CNT_W'(1);
    end

    // linear derate between the two temperature points
    always_comb begin
        // [R1] derate curve
        if (i_board_temp_c <= DERATE_START_C) begin
            derate = CURRENT_FULL;
        end else if (i_board_temp_c >= DERATE_ZERO_C) begin
            derate = 8'h00;
        end else begin
            derate = 8'({derate_diff[2:0], 5'h00});
        end
    end

    // ============================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.nvm_wr = 1'b0;
        s_d.ms_cnt = ms_tick ? 16'h0000 : s_q.ms_cnt + 16'h0001;

        // bus slave: zero wait, always OKAY
        s_d.hreadyout = 1'b1;
        s_d.ap_valid = ap_take;
        if (ap_take) begin
            s_d.ap_write = i_hwrite;
            s_d.ap_addr = {i_haddr[7:2], 2'b00};
            s_d.hrdata = i_hwrite ? 32'h0000_0000 : gmfm_read(s_q, {i_haddr[7:2], 2'b00});
        end
        if (wr_en) begin
            unique case (s_q.ap_addr)
                REG_CTRL: s_d.ctrl = i_hwdata[15:0];
                REG_START_SPD: begin
                    s_d.start1 = i_hwdata[15:0];
                    s_d.start2 = i_hwdata[31:16];
                end
                REG_RUN_SPD: s_d.run_spd = i_hwdata[15:0];
                REG_SFL: begin
                    s_d.sfl1 = i_hwdata[15:0];
                    s_d.sfl2 = i_hwdata[31:16];
                end
                REG_STOP_DLY: s_d.stop_dly = i_hwdata[15:0];
                default: s_d.ctrl = s_q.ctrl;
            endcase
        end

        // persistence timers and fault flags
        for (int i = 0; i < NFLT; i++) begin
            // [R19] restart on any gap
            if (!cond[i]) begin
                s_d.pcnt[i] = '0;
            end else if (s_q.pcnt[i] < plimit[i]) begin
                s_d.pcnt[i] = s_q.pcnt[i] + CNT_W'(1);
            end
            // set wins over any clear in the same cycle
            if (cond[i] && s_q.pcnt[i] >= plimit[i] - CNT_W'(1)) begin
                s_d.fault[i] = 1'b1;
            end else if (clr_ok[i]) begin
                // [R8] auto clear
                s_d.fault[i] = 1'b0;
            end
        end

        // [R10] sticky log, restored once after reset, set beats clear
        if (!s_q.log_loaded) begin
            s_d.log = i_nvm_log;
            s_d.log_loaded = 1'b1;
        end else begin
            s_d.log = (cmd_clrlog ? '0 : s_q.log) | s_d.fault;
            s_d.nvm_wr = (s_d.log != s_q.log);
        end

        // mode sequencer
        unique case (s_q.mode)
            M_STOPPING: begin
                // [R2] closed until speed zero
                if (speed_zero) begin
                    s_d.mode = M_STOPPED;
                    s_d.hold_cnt = 16'h0000;
                end
            end
            M_STOPPED: begin
                if (ms_tick && s_q.hold_cnt != s_q.stop_dly) begin
                    s_d.hold_cnt = s_q.hold_cnt + 16'h0001;
                end
                // [R4] power-down entry
                if (!i_run_enable) begin
                    s_d.mode = M_POWERDOWN;
                // [R3] start only with no shutdown; [R5] start fuel one
                end else if (!shutdown && i_speed_rpm > s_q.start1) begin
                    s_d.mode = M_START1;
                end
            end
            M_POWERDOWN: begin
                if (i_run_enable) begin
                    s_d.mode = M_STOPPED;
                    s_d.hold_cnt = 16'h0000;
                end
            end
            M_START1: begin
                // [R6] second start fuel when configured
                if (s_q.ctrl[CTRL_DUAL_BIT] && i_speed_rpm > s_q.start2) begin
                    s_d.mode = M_START2;
                end else if (i_speed_rpm >= s_q.run_spd) begin
                    s_d.mode = M_RAMPING;
                end
            end
            M_START2: begin
                if (i_speed_rpm >= s_q.run_spd) begin
                    s_d.mode = M_RAMPING;
                end
            end
            M_RAMPING: begin
                if (s_q.demand == i_rated_demand) begin
                    s_d.mode = M_RATED;
                end
            end
            M_RATED: s_d.mode = M_RATED;
            default: s_d.mode = M_STOPPING;
        endcase
        // [R7] shutdown pulls any running mode into stopping
        if (shutdown && running) begin
            s_d.mode = M_STOPPING;
        end

        // position demand per mode
        unique case (s_d.mode)
            // [R5] start fuel one value
            M_START1: s_d.demand = s_q.sfl1;
            // [R6] start fuel two value
            M_START2: s_d.demand = s_q.sfl2;
            M_RAMPING: begin
                // ramp one step per millisecond toward the rated demand
                if (!ms_tick) begin
                    s_d.demand = s_q.demand;
                end else if (s_q.demand + RAMP_STEP < i_rated_demand &&
                             s_q.demand < 16'hFFFF - RAMP_STEP) begin
                    s_d.demand = s_q.demand + RAMP_STEP;
                end else if (s_q.demand > i_rated_demand + RAMP_STEP &&
                             i_rated_demand < 16'hFFFF - RAMP_STEP) begin
                    s_d.demand = s_q.demand - RAMP_STEP;
                end else begin
                    s_d.demand = i_rated_demand;
                end
            end
            M_RATED: s_d.demand = i_rated_demand;
            default: s_d.demand = 16'h0000;
        endcase
        // [R7] minimum fuel on shutdown; [R20] stop commands too
        if (shutdown || s_d.fault[F_STOP]) begin
            s_d.demand = 16'h0000;
        end

        // actuator drive
        // [R4] controller off in power-down
        s_d.pos_en = (s_d.mode != M_POWERDOWN);
        // [R3] hold current after delay, or in power-down
        s_d.hold = (s_d.mode == M_POWERDOWN) ||
                   (s_d.mode == M_STOPPED && s_q.mode == M_STOPPED && s_q.hold_cnt == s_q.stop_dly);
        // [R18] failsafe direction by current control
        s_d.failsafe = s_d.fault[F_POS];
        if (s_d.fault[F_NVM] || s_d.fault[F_OTEMP]) begin
            // [R17] limp output
            s_d.climit = 8'h00;
        end else if (s_d.hold) begin
            s_d.climit = (s_q.ctrl[15:8] < derate) ? s_q.ctrl[15:8] : derate;
        end else begin
            // [R1] derated limit
            s_d.climit = derate;
        end

        // indications
        // [R9] healthy only with no fault
        s_d.healthy = (s_d.fault == '0);
        // [R14] external status opens
        s_d.ext_on = ((s_d.fault & EXT_STATUS_MASK) == '0);
    end

    assign shutdown = (s_q.fault != '0);

    // ============================================================
    // state register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            s_q <= '0;
            s_q.mode <= M_STOPPED;
            s_q.ctrl <= RST_CTRL;
            s_q.start1 <= RST_START1;
            s_q.start2 <= RST_START2;
            s_q.run_spd <= RST_RUN_SPD;
            s_q.sfl1 <= RST_SFL1;
            s_q.sfl2 <= RST_SFL2;
            s_q.stop_dly <= RST_STOP_DLY;
            s_q.pos_en <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops, except hresp, which is tied to OKAY
    assign o_hrdata = s_q.hrdata;
    assign o_hreadyout = s_q.hreadyout;
    assign o_hresp = 1'b0;
    assign o_nvm_log = s_q.log;
    assign o_nvm_log_wr = s_q.nvm_wr;
    assign o_pos_demand = s_q.demand;
    assign o_current_limit = s_q.climit;
    assign o_pos_ctrl_en = s_q.pos_en;
    assign o_hold_current = s_q.hold;
    assign o_failsafe_drive = s_q.failsafe;
    assign o_healthy = s_q.healthy;
    assign o_ext_status_on = s_q.ext_on;
    assign o_mode = s_q.mode;

endmodule : gmfm_top

// ==== gmfm_monitor.sv ====
// assertion checker bound to the governor mode and fault monitor
`timescale 1ns/10ps
module gmfm_chk
    import gmfm_pkg::*;
#(
    parameter int P_PERSIST_CYC = 20
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // watched inputs
    input wire logic [15:0] i_speed_rpm,
    input wire logic signed [11:0] i_board_temp_c,
    input wire logic i_run_enable,
    input wire logic i_stop_open,
    input wire logic i_nvm_fail,
    // watched outputs
    input wire logic [15:0] o_pos_demand,
    input wire logic [7:0] o_current_limit,
    input wire logic o_pos_ctrl_en,
    input wire logic o_hold_current,
    input wire logic o_healthy,
    input wire logic o_ext_status_on,
    input wire logic [6:0] o_mode
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // ============================================================
    // helper: stop request run length, saturating
    int stop_cnt_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !i_stop_open) begin
            stop_cnt_q <= 0;
        end else if (stop_cnt_q < P_PERSIST_CYC + 8) begin
            stop_cnt_q <= stop_cnt_q + 1;
        end
    end
    // ============================================================
    // properties
    sequence s_limp;
        (!o_healthy && !o_ext_status_on && o_current_limit == 8'h00) [*4];
    endsequence
    AST_DERATE_HOT: assert property ((i_board_temp_c >= DERATE_ZERO_C) [*3] |-> o_current_limit == 8'h00)
        else $error("current limit not zero at high temperature");
    AST_DERATE_COOL: assert property ((i_board_temp_c <= DERATE_START_C && o_ext_status_on && !o_hold_current) [*3]
        |-> o_current_limit == CURRENT_FULL)
        else $error("current limit not full at low temperature");
    AST_STOPPING_MIN: assert property (o_mode == M_STOPPING |-> o_pos_demand == 16'h0000)
        else $error("demand not minimum while stopping");
    AST_STOPPING_EXIT: assert property (o_mode == M_STOPPING && i_speed_rpm == 16'h0000 |=> o_mode == M_STOPPED)
        else $error("stopping did not move to stopped");
    AST_PDOWN_ENTRY: assert property ($rose(o_mode == M_POWERDOWN)
        |-> $past(o_mode) == M_STOPPED && !$past(i_run_enable))
        else $error("power-down entered from wrong state");
    AST_PDOWN_OUT: assert property (o_mode == M_POWERDOWN |-> !o_pos_ctrl_en && o_hold_current)
        else $error("power-down outputs wrong");
    AST_START1: assert property ($rose(o_mode == M_START1) |-> o_pos_demand == RST_SFL1)
        else $error("first start fuel demand wrong");
    AST_STOP_PERSIST: assert property (stop_cnt_q > P_PERSIST_CYC + 2 |-> !o_healthy)
        else $error("stop request not annunciated");
    AST_NVM_LIMP: assert property ($rose(i_nvm_fail) |-> ##3 s_limp)
        else $error("memory failure did not go limp");
endmodule : gmfm_chk
bind gmfm_top gmfm_chk #(.P_PERSIST_CYC(P_PERSIST_CYC)) i_gmfm_chk (.*);

// ==== gmfm_engine.sv ====
// engine speed pickup and actuator position sensor model
`timescale 1ns/10ps
module gmfm_engine (
    // clock
    input wire logic i_sys_clk,
    // bench controls
    input wire logic [15:0] i_speed_set,
    input wire logic i_pos_broken,
    // demand from the governor
    input wire logic [15:0] i_pos_demand,
    // sensed values
    output logic [15:0] o_speed_rpm,
    output logic [15:0] o_pos_sense_mv
);
    // pickup lags by a clock; a broken wiper reads above the valid band
    always_ff @(posedge i_sys_clk) begin
        o_speed_rpm <= i_speed_set;
        o_pos_sense_mv <= i_pos_broken ? 16'h1388 : 16'h0400 + {5'h00, i_pos_demand[15:5]};
    end
endmodule : gmfm_engine

// ==== gmfm_top_tb.sv ====
// self-checking bench for the governor mode and fault monitor
`timescale 1ns/10ps
module gmfm_top_tb
    import gmfm_pkg::*;
;
    logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0, i_run_enable = 1'b1;
    logic i_stop_open = 1'b0, i_nvm_fail = 1'b0, i_pos_broken = 1'b0;
    logic [1:0] i_htrans = 2'h0;
    logic [2:0] i_hsize = 3'h2;
    logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, rd;
    logic [15:0] i_supply_mv = 16'h5DC0, i_speed_set = 16'h0000, i_rated_demand = 16'h0040;
    logic [15:0] i_speed_rpm, i_pos_sense_mv, o_pos_demand;
    logic signed [11:0] i_board_temp_c = 12'sh019;
    logic [6:0] i_nvm_log = 7'h00, o_nvm_log, o_mode;
    logic [7:0] o_current_limit;
    logic i_hready, o_hreadyout, o_hresp, o_nvm_log_wr, o_pos_ctrl_en, o_hold_current;
    logic o_failsafe_drive, o_healthy, o_ext_status_on;
    int num_errors = 0, tests_run = 0, cycles = 0;
    // single slave: its readyout is the bus ready
    assign i_hready = o_hreadyout;
    // ============================================================
    // instances: short persistence so each fault trips within 20 cycles
    gmfm_top #(.P_PERSIST_CYC(20), .P_ZERO_SPEED_CYC(10), .P_MS_TICK_CYC(4)) i_gmfm_top (.*);
    gmfm_engine i_gmfm_engine (.i_sys_clk, .i_speed_set, .i_pos_broken, .i_pos_demand(o_pos_demand),
        .o_speed_rpm(i_speed_rpm), .o_pos_sense_mv(i_pos_sense_mv));
    // clock and hang guard
    initial begin
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ============================================================
    // tasks
    task automatic wt(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : wt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input logic signed [11:0] t, input logic [15:0] v, input int n, input logic [1:0] e);
        @(posedge i_sys_clk) i_board_temp_c <= t;
        i_supply_mv <= v;
        wt(n);
        chk(32'({o_healthy, o_ext_status_on}), 32'(e));
    endtask : step
    // single transfer: address until ready, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_hsel <= 1'b1;
        i_haddr <= {24'h000000, a};
        i_htrans <= 2'h2;
        i_hwrite <= wr;
        do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
        i_htrans <= 2'h0;
        i_hwdata <= d;
        do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
        rd = o_hrdata;
        i_hsel <= 1'b0;
    endtask : ahb
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    // ============================================================
    // main sequence
    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        ahb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h00004000);
        ahb(1'b0, REG_SFL, 32'h0);
        chk(rd, 32'h60008000);
        ahb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h00000000);
        ahb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h00010200);
        $display("registers done");
        @(posedge i_sys_clk) i_board_temp_c <= 12'sh079;
        wt(4);
        chk(32'(o_current_limit), 32'h80);
        step(12'sh082, 16'h5DC0, 26, 2'h0);
        step(12'sh07A, 16'h5DC0, 4, 2'h0);
        step(12'sh077, 16'h5DC0, 4, 2'h3);
        step(-12'sh032, 16'h5DC0, 26, 2'h0);
        step(-12'sh02A, 16'h5DC0, 4, 2'h0);
        step(-12'sh026, 16'h5DC0, 4, 2'h3);
        $display("temperature done");
        // two short dips whose sum exceeds the persistence time
        repeat (2) begin
            @(posedge i_sys_clk) i_supply_mv <= 16'h1770;
            wt(12);
            @(posedge i_sys_clk) i_supply_mv <= 16'h5DC0;
            wt(2);
        end
        chk(32'(o_healthy), 32'h1);
        step(12'sh019, 16'h84D0, 26, 2'h0);
        step(12'sh019, 16'h5DC0, 4, 2'h3);
        $display("supply done");
        ahb(1'b1, REG_CTRL, 32'h00004001);
        @(posedge i_sys_clk) i_speed_set <= 16'h0096;
        wt(4);
        chk(32'({o_mode, o_pos_demand}), 32'h00088000);
        @(posedge i_sys_clk) i_speed_set <= 16'h00FA;
        wt(4);
        chk(32'(o_mode), 32'h10);
        @(posedge i_sys_clk) i_speed_set <= 16'h0190;
        @(posedge i_sys_clk) i_stop_open <= 1'b1;
        wt(12);
        @(posedge i_sys_clk) i_stop_open <= 1'b0;
        wt(4);
        chk(32'(o_healthy), 32'h1);
        @(posedge i_sys_clk) i_stop_open <= 1'b1;
        wt(26);
        chk(32'({o_mode, o_pos_demand}), 32'h00010000);
        chk(32'({o_healthy, o_ext_status_on}), 32'h1);
        @(posedge i_sys_clk) i_speed_set <= 16'h0000;
        i_stop_open <= 1'b0;
        wt(6);
        chk(32'({o_mode, o_healthy}), 32'h5);
        ahb(1'b0, REG_LOG, 32'h0);
        chk(rd, 32'h00000017);
        ahb(1'b1, REG_CMD, 32'h00000002);
        ahb(1'b0, REG_LOG, 32'h0);
        chk(rd, 32'h00000000);
        $display("start and stop done");
        @(posedge i_sys_clk) i_run_enable <= 1'b0;
        wt(4);
        chk(32'({o_mode, o_pos_ctrl_en, o_hold_current}), 32'h11);
        @(posedge i_sys_clk) i_run_enable <= 1'b1;
        @(posedge i_sys_clk) i_pos_broken <= 1'b1;
        wt(26);
        chk(32'({o_failsafe_drive, o_healthy}), 32'h2);
        @(posedge i_sys_clk) i_pos_broken <= 1'b0;
        wt(4);
        chk(32'({o_failsafe_drive, o_healthy}), 32'h2);
        ahb(1'b1, REG_CMD, 32'h00000001);
        wt(4);
        chk(32'({o_failsafe_drive, o_healthy}), 32'h1);
        @(posedge i_sys_clk) i_speed_set <= 16'h0096;
        wt(4);
        @(posedge i_sys_clk) i_speed_set <= 16'h0010;
        wt(16);
        chk(32'({o_mode, o_healthy}), 32'h2);
        @(posedge i_sys_clk) i_nvm_fail <= 1'b1;
        wt(3);
        @(posedge i_sys_clk) i_nvm_fail <= 1'b0;
        wt(8);
        chk(32'({o_healthy, o_ext_status_on, o_current_limit}), 32'h0);
        $display("position and memory done");
        give_verdict();
    end
endmodule : gmfm_top_tb
